//--- verilog/scan_access_regs.svh
// constants for the scan port access control block
// assumes a single 100 MHz system clock and an 8-bit register port
`ifndef SCAN_ACCESS_REGS_SVH
`define SCAN_ACCESS_REGS_SVH
`define EN_REG_OFFSET   8'hC7
`define EN_BIT          0
`define EN_RESET        8'h00
`define SECTOR_COUNT    4'hC
`define IR_RESET        4'h1
`define IR_ENABLE       4'h1
`define IR_DISABLE      4'h2
`define IR_CLEAR        4'h3
`define IR_PROGRAM      4'h4
`define IR_SECTOR_ERASE 4'h5
`define IR_CHIP_ERASE   4'h6
`define IR_READ         4'h7
`define IR_BYPASS       4'hF
`define FC_NONE         3'h0
`define FC_PROGRAM      3'h1
`define FC_SECTOR_ERASE 3'h2
`define FC_CHIP_ERASE   3'h3
`define FC_READ         3'h4
`define BLANK_BYTE      8'hFF
`endif

//--- verilog/scan_access_pkg.sv
// types shared by the scan port access control block
// assumes scan_access_regs.svh holds the numeric constants
package scan_access_pkg;
  typedef enum logic [3:0] {
    tap_reset, tap_idle, sel_dr, cap_dr, sh_dr, ex1_dr, pa_dr, ex2_dr,
    up_dr, sel_ir, cap_ir, sh_ir, ex1_ir, pa_ir, ex2_ir, up_ir
  } tap_state_e;
  typedef logic [7:0]  byte_t;
  typedef logic [23:0] scan_word_t;
endpackage : scan_access_pkg

//--- verilog/scan_pin_sync.sv
// two-flop synchroniser for the scan pins and device reset, plus edges
// assumes all inputs are asynchronous to sys_clk
`timescale 1ns/1ns
module scan_pin_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // raw pins
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic device_reset_n,
  input  wire logic product_term_scan_select,
  // synchronised levels and clock edges
  output logic      tms_s,
  output logic      tdi_s,
  output logic      dev_rst_n_s,
  output logic      pt_sel_s,
  output logic      tck_rise,
  output logic      tck_fall
);
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic       tck_prev_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg     <= 5'h10;
      sync_reg     <= 5'h10;
      tck_prev_reg <= 1'b0;
    end else begin
      meta_reg     <= {device_reset_n, product_term_scan_select, tdi, tms,
                       tck};
      sync_reg     <= meta_reg;
      tck_prev_reg <= sync_reg[0];
    end
  end

  assign tms_s       = sync_reg[1];
  assign tdi_s       = sync_reg[2];
  assign pt_sel_s    = sync_reg[3];
  assign dev_rst_n_s = sync_reg[4];
  assign tck_rise    = sync_reg[0] & ~tck_prev_reg;
  assign tck_fall    = ~sync_reg[0] & tck_prev_reg;
endmodule : scan_pin_sync

//--- verilog/scan_access_ctrl.sv
// scan port access control: port enable, security, protection, ext pins
// assumes flash controller and mcu port run on sys_clk
`timescale 1ns/1ns
`include "scan_access_regs.svh"
module scan_access_ctrl import scan_access_pkg::*; (
  // clock and power-on reset
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  // device reset pin
  input  wire logic  device_reset_n,
  // mcu register port
  input  wire logic  [7:0] mcu_addr,
  input  wire logic  mcu_wr,
  input  wire logic  mcu_rd,
  input  wire byte_t mcu_wdata,
  output byte_t      mcu_rdata,
  // non-volatile configuration
  input  wire logic  nvm_dedicate,
  input  wire logic  nvm_security,
  input  wire logic  [11:0] nvm_sector_protect,
  input  wire logic  product_term_scan_select,
  // scan pins
  input  wire logic  tck,
  input  wire logic  tms,
  input  wire logic  tdi,
  output logic       tdo_out,
  output logic       tdo_oe,
  output logic       scan_active,
  // open drain extension pins
  output logic       program_status_out,
  output logic       program_status_oe,
  output logic       program_error_out,
  output logic       program_error_oe,
  // flash controller
  output logic       flash_req,
  output logic [2:0] flash_cmd,
  output logic [15:0] flash_addr,
  output byte_t      flash_wdata,
  output logic       flash_abort,
  input  wire logic  flash_busy,
  input  wire logic  flash_fail,
  input  wire byte_t flash_rdata
);
  logic       tms_s, tdi_s, dev_rst_n_s, pt_sel_s, tck_rise, tck_fall;
  tap_state_e tap_state_reg, tap_state_next;
  byte_t      en_reg, rd_byte;
  scan_word_t dr_reg;
  logic [3:0] ir_reg, ir_shift_reg, sector;
  logic [11:0] prot_reg;
  logic [2:0] op_reg, req_cmd;
  logic       sec_reg, blank_reg, dedicate_reg, load_reg;
  logic       isc_reg, ext_reg, disabled_reg, err_reg, busy_q_reg;
  logic       port_hold, scan_on, live, upd_dr, req_ok, op_done;

  scan_pin_sync i_scan_pin_sync (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .tck                      (tck),
    .tms                      (tms),
    .tdi                      (tdi),
    .device_reset_n           (device_reset_n),
    .product_term_scan_select (product_term_scan_select),
    .tms_s                    (tms_s),
    .tdi_s                    (tdi_s),
    .dev_rst_n_s              (dev_rst_n_s),
    .pt_sel_s                 (pt_sel_s),
    .tck_rise                 (tck_rise),
    .tck_fall                 (tck_fall)
  );

  // port enable and reset interplay
  assign port_hold = ~dev_rst_n_s & ~dedicate_reg;
  assign scan_on   = dedicate_reg | en_reg[`EN_BIT] | pt_sel_s;
  assign live      = scan_on & ~port_hold;
  assign upd_dr    = live & tck_rise & (tap_state_reg == up_dr);
  assign op_done   = busy_q_reg & ~flash_busy;
  assign sector    = dr_reg[15:12];

  // enable register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= `EN_RESET;
    end else if (!dev_rst_n_s) begin
      en_reg <= `EN_RESET;
    end else if (mcu_wr && mcu_addr == `EN_REG_OFFSET) begin
      en_reg <= mcu_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcu_rdata <= 8'h00;
    end else if (mcu_rd && mcu_addr == `EN_REG_OFFSET) begin
      mcu_rdata <= en_reg;
    end else begin
      mcu_rdata <= 8'h00;
    end
  end

  // configuration capture after reset, chip erase returns security and protection to blank
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_reg     <= 1'b0;
      sec_reg      <= 1'b0;
      prot_reg     <= 12'h000;
      dedicate_reg <= 1'b0;
      blank_reg    <= 1'b0;
    end else if (!load_reg) begin
      load_reg     <= 1'b1;
      sec_reg      <= nvm_security;
      prot_reg     <= nvm_sector_protect;
      dedicate_reg <= nvm_dedicate;
    end else if (op_done && op_reg == `FC_CHIP_ERASE && !flash_fail &&
                 !flash_abort) begin
      sec_reg   <= 1'b0;
      prot_reg  <= 12'h000;
      blank_reg <= 1'b1;
    end else if (op_done && op_reg == `FC_PROGRAM) begin
      blank_reg <= 1'b0;
    end
  end

  // scan state machine
  always_comb begin
    case (tap_state_reg)
      tap_reset: tap_state_next = tms_s ? tap_reset : tap_idle;
      tap_idle:  tap_state_next = tms_s ? sel_dr : tap_idle;
      sel_dr:    tap_state_next = tms_s ? sel_ir : cap_dr;
      cap_dr:    tap_state_next = tms_s ? ex1_dr : sh_dr;
      sh_dr:     tap_state_next = tms_s ? ex1_dr : sh_dr;
      ex1_dr:    tap_state_next = tms_s ? up_dr : pa_dr;
      pa_dr:     tap_state_next = tms_s ? ex2_dr : pa_dr;
      ex2_dr:    tap_state_next = tms_s ? up_dr : sh_dr;
      up_dr:     tap_state_next = tms_s ? sel_dr : tap_idle;
      sel_ir:    tap_state_next = tms_s ? tap_reset : cap_ir;
      cap_ir:    tap_state_next = tms_s ? ex1_ir : sh_ir;
      sh_ir:     tap_state_next = tms_s ? ex1_ir : sh_ir;
      ex1_ir:    tap_state_next = tms_s ? up_ir : pa_ir;
      pa_ir:     tap_state_next = tms_s ? ex2_ir : pa_ir;
      ex2_ir:    tap_state_next = tms_s ? up_ir : sh_ir;
      up_ir:     tap_state_next = tms_s ? sel_dr : tap_idle;
      default:   tap_state_next = tap_reset;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_state_reg <= tap_reset;
    end else if (!live) begin
      tap_state_reg <= tap_reset;
    end else if (tck_rise) begin
      tap_state_reg <= tap_state_next;
    end
  end

  // instruction and data shift
  always_comb begin
    if (sec_reg) begin
      rd_byte = 8'h00;
    end else if (blank_reg) begin
      rd_byte = `BLANK_BYTE;
    end else begin
      rd_byte = flash_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_reg       <= `IR_BYPASS;
      ir_shift_reg <= 4'h0;
      dr_reg       <= 24'h000000;
    end else if (tap_state_reg == tap_reset) begin
      ir_reg <= `IR_BYPASS;
    end else if (live && tck_rise) begin
      case (tap_state_reg)
        cap_ir:  ir_shift_reg <= `IR_RESET;
        sh_ir:   ir_shift_reg <= {tdi_s, ir_shift_reg[3:1]};
        up_ir:   ir_reg <= ir_shift_reg;
        cap_dr:  dr_reg <= {rd_byte, 13'h0000, sec_reg, err_reg,
                            busy_q_reg};
        sh_dr:   dr_reg <= {tdi_s, dr_reg[23:1]};
        default: dr_reg <= dr_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_out     <= 1'b0;
      tdo_oe      <= 1'b0;
      scan_active <= 1'b0;
    end else begin
      scan_active <= live;
      tdo_oe      <= live & (tap_state_reg == sh_dr ||
                             tap_state_reg == sh_ir);
      if (tck_fall) begin
        tdo_out <= (tap_state_reg == sh_ir) ? ir_shift_reg[0] : dr_reg[0];
      end
    end
  end

  // command gating by security and sector protection
  always_comb begin
    req_ok  = 1'b0;
    req_cmd = `FC_NONE;
    case (ir_reg)
      `IR_PROGRAM: begin
        req_ok  = ~sec_reg;
        req_cmd = `FC_PROGRAM;
      end
      `IR_SECTOR_ERASE: begin
        req_ok  = ~sec_reg & (sector < `SECTOR_COUNT) &
                  ~prot_reg[sector];
        req_cmd = `FC_SECTOR_ERASE;
      end
      `IR_CHIP_ERASE: begin
        req_ok  = 1'b1;
        req_cmd = `FC_CHIP_ERASE;
      end
      `IR_READ: begin
        req_ok  = ~sec_reg;
        req_cmd = `FC_READ;
      end
      default: begin
        req_ok  = 1'b0;
        req_cmd = `FC_NONE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_req   <= 1'b0;
      flash_cmd   <= `FC_NONE;
      flash_addr  <= 16'h0000;
      flash_wdata <= 8'h00;
      flash_abort <= 1'b0;
      op_reg      <= `FC_NONE;
      busy_q_reg  <= 1'b0;
    end else begin
      busy_q_reg  <= flash_busy;
      flash_abort <= port_hold & flash_busy;
      flash_req   <= upd_dr & isc_reg & req_ok & ~flash_busy;
      if (upd_dr && isc_reg && req_ok && !flash_busy) begin
        flash_cmd   <= req_cmd;
        flash_addr  <= dr_reg[15:0];
        flash_wdata <= dr_reg[23:16];
        op_reg      <= req_cmd;
      end
    end
  end

  // enable, disable and clear; error flag, set wins over clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      isc_reg      <= 1'b0;
      ext_reg      <= 1'b0;
      disabled_reg <= 1'b0;
      err_reg      <= 1'b0;
    end else begin
      if (upd_dr && ir_reg == `IR_ENABLE) begin
        isc_reg      <= 1'b1;
        ext_reg      <= dr_reg[0];
        disabled_reg <= 1'b0;
      end else if (upd_dr && ir_reg == `IR_DISABLE) begin
        isc_reg      <= 1'b0;
        ext_reg      <= 1'b0;
        disabled_reg <= 1'b1;
      end
      if (flash_fail && (op_reg == `FC_PROGRAM ||
                         op_reg == `FC_SECTOR_ERASE)) begin
        err_reg <= 1'b1;
      end else if ((upd_dr && ir_reg == `IR_CLEAR) ||
                   (!dev_rst_n_s && disabled_reg)) begin
        err_reg <= 1'b0;
      end
    end
  end

  // open drain pins: drive low only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_status_out <= 1'b0;
      program_status_oe  <= 1'b0;
      program_error_out  <= 1'b0;
      program_error_oe   <= 1'b0;
    end else begin
      program_status_out <= 1'b0;
      program_error_out  <= 1'b0;
      program_status_oe  <= ext_reg & flash_busy;
      program_error_oe   <= ext_reg & err_reg;
    end
  end

  // checks
  property p_open_drain;
    @(posedge sys_clk) disable iff (!rst_n)
      program_status_oe |-> !program_status_out && $past(ext_reg);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("status pin driven without enable");

  property p_secure_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (live && tck_rise && tap_state_reg == cap_dr && sec_reg)
        |=> dr_reg[23:16] == 8'h00;
  endproperty
  a_secure_read: assert property (p_secure_read)
    else $error("secured read returned data");

  property p_secure_only_erase;
    @(posedge sys_clk) disable iff (!rst_n)
      (flash_req && $past(sec_reg)) |-> flash_cmd == `FC_CHIP_ERASE;
  endproperty
  a_secure_only_erase: assert property (p_secure_only_erase)
    else $error("secured part issued a non chip erase command");

  property p_secure_block;
    @(posedge sys_clk) disable iff (!rst_n)
      (upd_dr && sec_reg && ir_reg == `IR_PROGRAM) |=> !flash_req;
  endproperty
  a_secure_block: assert property (p_secure_block)
    else $error("secured program reached the flash");

  property p_erase_unlocks;
    @(posedge sys_clk) disable iff (!rst_n)
      (load_reg && op_done && op_reg == `FC_CHIP_ERASE && !flash_fail &&
       !flash_abort)
        |=> !sec_reg && blank_reg && prot_reg == 12'h000;
  endproperty
  a_erase_unlocks: assert property (p_erase_unlocks)
    else $error("chip erase left part secured");

  property p_protect;
    @(posedge sys_clk) disable iff (!rst_n)
      (flash_req && flash_cmd == `FC_SECTOR_ERASE)
        |-> ($past(prot_reg) & (12'h001 << flash_addr[15:12])) == 12'h000;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected sector erased");

  property p_enable_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (mcu_wr && mcu_addr == `EN_REG_OFFSET && dev_rst_n_s)
        |=> en_reg[`EN_BIT] == $past(mcu_wdata[`EN_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable bit did not follow write");

  property p_reset_abort;
    @(posedge sys_clk) disable iff (!rst_n)
      (!dev_rst_n_s && !dedicate_reg) |=> tap_state_reg == tap_reset &&
        !scan_active;
  endproperty
  a_reset_abort: assert property (p_reset_abort)
    else $error("device reset did not stop the port");

  property p_reset_clears_en;
    @(posedge sys_clk) disable iff (!rst_n)
      !dev_rst_n_s |=> en_reg == `EN_RESET;
  endproperty
  a_reset_clears_en: assert property (p_reset_clears_en)
    else $error("device reset left enable set");

  property p_status_busy;
    @(posedge sys_clk) disable iff (!rst_n)
      (ext_reg && flash_busy) |=> program_status_oe;
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("status pin not low while busy");

  c_chip_erase: cover property (@(posedge sys_clk) disable iff (!rst_n)
    flash_req && flash_cmd == `FC_CHIP_ERASE);
  c_blocked: cover property (@(posedge sys_clk) disable iff (!rst_n)
    upd_dr && sec_reg && ir_reg == `IR_PROGRAM);
  c_error_pin: cover property (@(posedge sys_clk) disable iff (!rst_n)
    program_error_oe);
endmodule : scan_access_ctrl

//--- dv/scan_prog_model.sv
// external scan programming controller: drives the link clock and pins
// assumes the device samples tck with its own clock; tck idles low
`timescale 1ns/1ns
module scan_prog_model (
  // scan pins toward the device
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  // answer from the device
  input  wire logic tdo_out,
  input  wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one 125 ns link cycle; bit seen at the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62 tck = 1'b1;
    q = tdo_oe ? tdo_out : ~d;
    #63 tck = 1'b0;
    tdi = ~d;
  endtask : step

  // five ones reach test-logic-reset, then park in idle
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : tap_reset

  // idle -> shift-ir, four bits lsb first, update, idle
  task automatic shift_ir(input logic [3:0] code);
    logic q;
    step(1'b1, 1'b0, q);
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < 4; i++) begin
      step(i == 3, code[i], q);
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : shift_ir

  // idle -> shift-dr, 24 bits lsb first, update, idle
  task automatic shift_dr(input logic [23:0] din, output logic [23:0] dout);
    logic q;
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < 24; i++) begin
      step(i == 23, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : shift_dr
endmodule : scan_prog_model

//--- dv/jtag_isp_security_access_tb.sv
// self-checking bench for the scan port access control block
// assumes a flash controller model here and the scan model beside it
`timescale 1ns/1ns
`include "scan_access_regs.svh"
module jtag_isp_security_access_tb;
  logic        sys_clk, rst_n, device_reset_n, mcu_wr, mcu_rd;
  logic        nvm_dedicate, nvm_security, product_term_scan_select;
  logic        tck, tms, tdi, tdo_out, tdo_oe, scan_active;
  logic        program_status_out, program_status_oe;
  logic        program_error_out, program_error_oe;
  logic        flash_req, flash_abort;
  logic        flash_busy = 1'b0;
  logic        flash_fail = 1'b0;
  logic        seen_abort = 1'b0;
  logic        fail_next  = 1'b0;
  logic [7:0]  mcu_addr, mcu_wdata, mcu_rdata, flash_wdata, d;
  logic [7:0]  flash_rdata = 8'h5A;
  logic [11:0] nvm_sector_protect;
  logic [2:0]  flash_cmd;
  logic [15:0] flash_addr;
  logic [23:0] cap, r;
  logic [23:0] req_count = 24'h000000;
  int          busy_left = 0;
  int          busy_len  = 60;
  int          fail_count = 0;
  int          total_checks = 0;

  scan_access_ctrl i_scan_access_ctrl (.sys_clk, .rst_n, .device_reset_n,
    .mcu_addr, .mcu_wr, .mcu_rd, .mcu_wdata, .mcu_rdata, .nvm_dedicate,
    .nvm_security, .nvm_sector_protect, .product_term_scan_select,
    .tck, .tms, .tdi, .tdo_out, .tdo_oe, .scan_active, .program_status_out,
    .program_status_oe, .program_error_out, .program_error_oe, .flash_req,
    .flash_cmd, .flash_addr, .flash_wdata, .flash_abort, .flash_busy,
    .flash_fail, .flash_rdata);

  scan_prog_model i_scan_prog_model (.tck, .tms, .tdi, .tdo_out, .tdo_oe);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // flash controller: busy for busy_len cycles, optional fail at the end
  always @(posedge sys_clk) begin
    if (flash_abort) seen_abort <= 1'b1;
    flash_fail <= !flash_req && flash_busy && busy_left == 1 && fail_next &&
                  !flash_abort;
    if (flash_req) begin
      req_count  <= req_count + 24'h000001;
      flash_busy <= 1'b1;
      busy_left  <= busy_len;
    end else if (flash_busy) begin
      if (busy_left == 1 || flash_abort) begin
        flash_busy <= 1'b0;
      end
      busy_left <= busy_left - 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc

  task automatic mcu_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    #1 mcu_addr = a;
    mcu_wdata = v;
    mcu_wr = 1'b1;
    @(posedge sys_clk);
    #1 mcu_wr = 1'b0;
  endtask : mcu_write

  task automatic mcu_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    #1 mcu_addr = a;
    mcu_rd = 1'b1;
    @(posedge sys_clk);
    #1 mcu_rd = 1'b0;
    v = mcu_rdata;
  endtask : mcu_read

  task automatic por(input logic ded, input logic sec, input logic [11:0] p);
    @(posedge sys_clk);
    #1 rst_n = 1'b0;
    nvm_dedicate = ded;
    nvm_security = sec;
    nvm_sector_protect = p;
    wait_cyc(12);
    rst_n = 1'b1;
    wait_cyc(6);
  endtask : por

  task automatic op(input logic [3:0] ir, input logic [23:0] dr);
    i_scan_prog_model.shift_ir(ir);
    i_scan_prog_model.shift_dr(dr, cap);
    wait_cyc(4);
  endtask : op

  // reset the tap, then enable the port with the extension pins on
  task automatic start();
    i_scan_prog_model.tap_reset();
    op(`IR_ENABLE, 24'h000001);
    r = req_count;
  endtask : start

  task automatic wait_flash();
    int n = 0;
    while (flash_busy !== 1'b0 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    wait_cyc(4);
  endtask : wait_flash

  initial begin
    #900000;
    fail_count++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    device_reset_n = 1'b1;
    mcu_wr = 1'b0;
    mcu_rd = 1'b0;
    mcu_addr = 8'h00;
    mcu_wdata = 8'h00;
    product_term_scan_select = 1'b0;
    por(1'b0, 1'b0, 12'h000);
    mcu_read(`EN_REG_OFFSET, d);
    check(d, 8'h00);
    mcu_read(8'h10, d);
    check(d, 8'h00);
    check(scan_active, 1'b0);
    mcu_write(`EN_REG_OFFSET, 8'h01);
    wait_cyc(4);
    check(scan_active, 1'b1);
    mcu_read(`EN_REG_OFFSET, d);
    check(d, 8'h01);
    mcu_write(`EN_REG_OFFSET, 8'h00);
    wait_cyc(4);
    check(scan_active, 1'b0);
    mcu_write(`EN_REG_OFFSET, 8'h01);
    wait_cyc(4);
    // failing program with extension pins watched
    start();
    check(program_error_oe, 1'b0);
    fail_next = 1'b1;
    op(`IR_PROGRAM, {8'hA5, 16'h0123});
    check(req_count, r + 24'h1);
    check(flash_cmd, `FC_PROGRAM);
    check({flash_addr, flash_wdata}, 24'h0123A5);
    check(program_status_oe, 1'b1);
    check(program_status_out, 1'b0);
    wait_flash();
    check(program_error_oe, 1'b1);
    check(program_error_out, 1'b0);
    check(program_status_oe, 1'b0);
    fail_next = 1'b0;
    op(`IR_CLEAR, 24'h000000);
    check(program_error_oe, 1'b0);
    // error flag holds until a reset that follows a disable
    fail_next = 1'b1;
    op(`IR_PROGRAM, {8'hC3, 16'h0200});
    wait_flash();
    fail_next = 1'b0;
    op(`IR_DISABLE, 24'h000000);
    check(cap[1], 1'b1);
    check(program_error_oe, 1'b0);
    device_reset_n = 1'b0;
    wait_cyc(6);
    device_reset_n = 1'b1;
    wait_cyc(6);
    mcu_write(`EN_REG_OFFSET, 8'h01);
    wait_cyc(4);
    start();
    check(cap[1], 1'b0);
    // sector protection, port opened by the product term
    por(1'b0, 1'b0, 12'h102);
    product_term_scan_select = 1'b1;
    wait_cyc(6);
    check(scan_active, 1'b1);
    start();
    op(`IR_SECTOR_ERASE, 24'h001000);
    op(`IR_SECTOR_ERASE, 24'h008000);
    check(req_count, r);
    op(`IR_SECTOR_ERASE, 24'h002000);
    check(req_count, r + 24'h1);
    check(flash_cmd, `FC_SECTOR_ERASE);
    wait_flash();
    op(`IR_READ, 24'h000000);
    check(cap, 24'h5A0000);
    wait_flash();
    product_term_scan_select = 1'b0;
    // secured part: only chip erase passes
    por(1'b0, 1'b1, 12'h000);
    mcu_write(`EN_REG_OFFSET, 8'h01);
    wait_cyc(4);
    start();
    op(`IR_READ, 24'h000000);
    check(cap, 24'h000004);
    op(`IR_PROGRAM, 24'h002000);
    op(`IR_SECTOR_ERASE, 24'h002000);
    check(req_count, r);
    op(`IR_CHIP_ERASE, 24'h000000);
    check(req_count, r + 24'h1);
    check(flash_cmd, `FC_CHIP_ERASE);
    wait_flash();
    op(`IR_READ, 24'h000000);
    check(cap, 24'hFF0000);
    check(cap[23:16], `BLANK_BYTE);
    check(flash_cmd, `FC_READ);
    wait_flash();
    // device reset aborts when enabled by the register only
    busy_len = 500;
    op(`IR_CHIP_ERASE, 24'h000000);
    device_reset_n = 1'b0;
    wait_cyc(8);
    check(scan_active, 1'b0);
    check(seen_abort, 1'b1);
    wait_flash();
    r = req_count;
    i_scan_prog_model.tap_reset();
    op(`IR_ENABLE, 24'h000001);
    op(`IR_CHIP_ERASE, 24'h000000);
    check(req_count, r);
    device_reset_n = 1'b1;
    wait_cyc(6);
    mcu_read(`EN_REG_OFFSET, d);
    check(d, 8'h00);
    // dedicated port ignores device reset
    busy_len = 20;
    por(1'b1, 1'b0, 12'h000);
    check(scan_active, 1'b1);
    device_reset_n = 1'b0;
    wait_cyc(8);
    check(scan_active, 1'b1);
    start();
    op(`IR_PROGRAM, {8'h3C, 16'h0040});
    check(req_count, r + 24'h1);
    device_reset_n = 1'b1;
    wait_flash();
    finish_test();
  end
endmodule : jtag_isp_security_access_tb
